// ### logic/flash_op_timer.sv
// Purpose: Times one flash erase or write operation
// Assumes: start_in is a one-cycle pulse while idle
// Notes: done_out pulses once, CYCLES edges after the start edge
`timescale 1ns/1ps
module flash_op_timer #(
  parameter int CYCLES = flash_spm_pkg::OP_MIN_CYCLES // Operation length in cycles
) (
  input wire logic clk_sys_in, // System clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic start_in, // Start pulse
  output logic done_out // Completion pulse
);
  // A zero-length operation would never raise done
  generate
    if (CYCLES < 1) begin : g_bad_cycles
      $error("CYCLES must be at least 1");
    end
  endgenerate

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic run;
  logic [CW-1:0] cnt;
  wire logic at_last = run & (cnt == LAST);

  // Count from the start pulse until the last cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      run <= 1'b0;
      cnt <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= at_last;
      run <= start_in | (run & ~at_last);
      cnt <= start_in ? '0 : cnt + 1'b1;
    end
  end
endmodule

// ### logic/flash_spm_pkg.sv
// Purpose: Shared constants and types for the flash self-program sequencer
// Assumes: 10 MHz system clock, Avalon-MM register access, byte addresses
// Notes: Summary of operation follows
package flash_spm_pkg;
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [7:0] CMD_LOAD = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam int CLEAR_BIT = 4;
  localparam logic [2:0] WINDOW_CYCLES = 3'h4;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FUSE = 1;
  localparam int STAT_EEPROM = 2;
  localparam int STAT_LOADED = 3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OP_MIN_NS = 3700000;
  localparam int OP_MAX_NS = 4500000;
  localparam int OP_MIN_CYCLES = (OP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OP_MAX_CYCLES = OP_MAX_NS / CLK_PERIOD_NS;
  // One store-program instruction from the core
  typedef struct packed {
    logic strobe;
    logic [15:0] z;
    logic [15:0] word;
  } spm_req_t;
  // Command to the flash array
  typedef struct packed {
    logic erase;
    logic write;
    logic [14:0] addr;
    logic [15:0] data;
  } flash_cmd_t;
endpackage

// ### logic/flash_spm_seq.sv
// Purpose: Self-program sequencer for the on-chip program flash
// Assumes: Core stalls on stall_cpu_out; flash read returns a word one cycle after address
// Notes: Command and status registers sit on an Avalon-MM slave with waitrequest
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module flash_spm_seq #(
  parameter int PAGE_WORDS = 32, // Words per flash page
  parameter int OP_CYCLES = flash_spm_pkg::OP_MIN_CYCLES // Erase or write length
) (
  input wire logic clk_sys_in, // 10 MHz system clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic [3:0] avs_address_in, // Register byte address
  input wire logic avs_read_in, // Read request
  input wire logic avs_write_in, // Write request
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic [3:0] avs_byteenable_in, // Byte lanes
  output logic [31:0] avs_readdata_out, // Read data
  output logic avs_waitrequest_out, // Stall the bus master
  input wire flash_spm_pkg::spm_req_t spm_in, // Store-program instruction
  input wire logic self_program_fuse_in, // Fuse, 0 when programmed
  input wire logic eeprom_write_active_in, // EEPROM write in progress
  output logic stall_cpu_out, // Halt the core
  output flash_spm_pkg::flash_cmd_t flash_cmd_out, // Erase and word write commands
  input wire logic [15:0] lpm_z_in, // Z pointer of a byte read
  input wire logic [15:0] flash_rd_word_in, // Word from flash array
  output logic [14:0] flash_rd_addr_out, // Word address to flash array
  output logic [7:0] lpm_byte_out // Selected byte
);
  localparam int WBITS = $clog2(PAGE_WORDS);
  localparam int PBITS = 15 - WBITS;

  typedef enum logic [1:0] {IDLE, ERASING, WRITING} op_state_t;

  // Refuse page sizes the addressing cannot serve
  generate
    if (PAGE_WORDS < 2 || PAGE_WORDS > 256 ||
        (PAGE_WORDS & (PAGE_WORDS - 1)) != 0) begin : g_bad_page
      $error("PAGE_WORDS must be a power of two from 2 to 256");
    end
    if (OP_CYCLES < 1 || OP_CYCLES > flash_spm_pkg::OP_MAX_CYCLES) begin : g_bad_time
      $error("OP_CYCLES out of range");
    end
  endgenerate

  op_state_t state;
  logic wait_q;
  logic [2:0] cmd_q;
  logic [2:0] win_q;
  logic [PBITS-1:0] page_q;
  logic [WBITS:0] stream_q;
  logic [PAGE_WORDS-1:0] loaded;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic lpm_sel_q;
  logic op_done;

  // Bus decode: a request completes at the edge where waitrequest is low
  wire logic bus_req = avs_read_in | avs_write_in;
  wire logic bus_take = bus_req & ~wait_q;
  wire logic cmd_sel = avs_address_in == flash_spm_pkg::ADDR_CMD;
  wire logic stat_sel = avs_address_in == flash_spm_pkg::ADDR_STATUS;
  wire logic [7:0] wr_byte = avs_writedata_in[7:0];
  wire logic idle = state == IDLE;
  wire logic cmd_wr = bus_take & avs_write_in & cmd_sel & avs_byteenable_in[0];
  // Command writes are blocked while an EEPROM write runs
  wire logic cmd_ok = cmd_wr & idle & ~eeprom_write_active_in;
  wire logic is_load = wr_byte == flash_spm_pkg::CMD_LOAD;
  wire logic is_erase = wr_byte == flash_spm_pkg::CMD_ERASE;
  wire logic is_write = wr_byte == flash_spm_pkg::CMD_WRITE;
  wire logic [2:0] next_cmd = (is_load | is_erase | is_write) ? wr_byte[2:0] : 3'h0;
  wire logic clear_req = cmd_ok & wr_byte[flash_spm_pkg::CLEAR_BIT];

  // Store-program acceptance
  wire logic fuse_ok = self_program_fuse_in == flash_spm_pkg::FUSE_PROGRAMMED;
  wire logic in_window = win_q != 3'h0;
  wire logic spm_ok = spm_in.strobe & fuse_ok & ~eeprom_write_active_in & in_window & idle;
  wire logic load_en = spm_ok & (cmd_q == flash_spm_pkg::CMD_LOAD[2:0]);
  wire logic erase_go = spm_ok & (cmd_q == flash_spm_pkg::CMD_ERASE[2:0]);
  wire logic write_go = spm_ok & (cmd_q == flash_spm_pkg::CMD_WRITE[2:0]);
  wire logic op_go = erase_go | write_go;

  // Z splits into word-in-page and page fields; bit 0 is unused for commands
  wire logic [WBITS-1:0] word_idx = spm_in.z[WBITS:1];
  wire logic [PBITS-1:0] page_idx = spm_in.z[15:WBITS+1];

  // Buffer clear events
  wire logic write_end = op_done & (state == WRITING);
  wire logic eeprom_hit = eeprom_write_active_in & (|loaded);
  wire logic clear_all = clear_req | write_end | eeprom_hit;

  // Page streaming to the flash array during a page write
  wire logic streaming = (state == WRITING) & ~stream_q[WBITS];
  wire logic [WBITS-1:0] stream_idx = stream_q[WBITS-1:0];
  wire logic [15:0] stream_word = loaded[stream_idx] ? buf_mem[stream_idx] :
                                  flash_spm_pkg::ERASED_WORD;
  wire logic window_expire = (win_q == 3'h1) & ~spm_ok;

  // Register read mux, unmapped addresses read zero
  wire logic [31:0] stat_word = {28'h0, |loaded, eeprom_write_active_in,
                                 self_program_fuse_in, ~idle};
  wire logic [31:0] next_rdata = cmd_sel ? {29'h0, cmd_q} :
                                 stat_sel ? stat_word : 32'h0;

  // Erase and write duration
  flash_op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .start_in(op_go),
    .done_out(op_done)
  );

  // Bus handshake: waitrequest drops for one cycle per request
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wait_q <= 1'b1;
      avs_readdata_out <= 32'h0;
    end else begin
      wait_q <= ~(bus_req & wait_q);
      if (bus_req & wait_q) begin
        avs_readdata_out <= next_rdata;
      end
    end
  end
  assign avs_waitrequest_out = wait_q;

  // Pending command and its four-cycle window
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cmd_q <= 3'h0;
      win_q <= 3'h0;
    end else if (cmd_ok) begin
      cmd_q <= next_cmd;
      win_q <= (next_cmd != 3'h0) ? flash_spm_pkg::WINDOW_CYCLES : 3'h0;
    end else if (load_en | op_done | window_expire) begin
      cmd_q <= 3'h0;
      win_q <= 3'h0;
    end else if (op_go) begin
      win_q <= 3'h0;
    end else if (in_window) begin
      win_q <= win_q - 3'h1;
    end
  end

  // Operation state and core stall
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state <= IDLE;
      stall_cpu_out <= 1'b0;
      page_q <= '0;
    end else if (op_go) begin
      state <= erase_go ? ERASING : WRITING;
      stall_cpu_out <= 1'b1;
      page_q <= page_idx;
    end else if (op_done) begin
      state <= IDLE;
      stall_cpu_out <= 1'b0;
    end
  end

  // Word counter for page streaming
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || op_go) begin
      stream_q <= '0;
    end else if (streaming) begin
      stream_q <= stream_q + 1'b1;
    end
  end

  // Flash array commands
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      flash_cmd_out <= '0;
    end else begin
      flash_cmd_out.erase <= erase_go;
      flash_cmd_out.write <= streaming;
      flash_cmd_out.addr <= erase_go ? {page_idx, {WBITS{1'b0}}} : {page_q, stream_idx};
      flash_cmd_out.data <= stream_word;
    end
  end

  // Buffer storage, one word per accepted load
  always_ff @(posedge clk_sys_in) begin
    if (load_en) begin
      buf_mem[word_idx] <= spm_in.word;
    end
  end

  // Per-word loaded flags, cleared together
  generate
    for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_loaded
      always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || clear_all) begin
          loaded[i] <= 1'b0;
        end else if (load_en && word_idx == WBITS'(i)) begin
          loaded[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // Byte read path: Z bit 0 picks the byte of the word
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      flash_rd_addr_out <= 15'h0;
      lpm_sel_q <= 1'b0;
      lpm_byte_out <= 8'h0;
    end else begin
      flash_rd_addr_out <= lpm_z_in[15:1];
      lpm_sel_q <= lpm_z_in[0];
      lpm_byte_out <= lpm_sel_q ? flash_rd_word_in[15:8] : flash_rd_word_in[7:0];
    end
  end

  // Helper: length of each stall
  logic [17:0] stall_len;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      stall_len <= 18'h0;
    end else begin
      stall_len <= stall_cpu_out ? stall_len + 18'h1 : 18'h0;
    end
  end

  localparam int STALL_CYCLES = OP_CYCLES + 1;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  property p_fuse_gate;
    spm_in.strobe && (self_program_fuse_in != flash_spm_pkg::FUSE_PROGRAMMED)
      |=> !stall_cpu_out && $stable(loaded);
  endproperty
  a_fuse_gate: assert property (p_fuse_gate)
    else $error("store-program acted with fuse off");

  property p_load_sets;
    load_en |=> loaded[$past(word_idx)] && (cmd_q == 3'h0);
  endproperty
  a_load_sets: assert property (p_load_sets) else $error("buffer word not marked loaded");

  property p_window;
    cmd_ok && next_cmd != 3'h0 ##1 !spm_in.strobe [*4] |=> cmd_q == 3'h0;
  endproperty
  a_window: assert property (p_window) else $error("pending command outlived its window");

  property p_erase_stall;
    erase_go |=> stall_cpu_out && flash_cmd_out.erase ##1 stall_cpu_out [*8];
  endproperty
  a_erase_stall: assert property (p_erase_stall)
    else $error("core not stalled during erase");

  property p_write_stall;
    write_go |=> stall_cpu_out && state == WRITING
      ##1 (stall_cpu_out && state == WRITING) [*8];
  endproperty
  a_write_stall: assert property (p_write_stall)
    else $error("core not stalled during page write");

  property p_write_clears;
    (op_done && state == WRITING) |=> loaded == '0 && !stall_cpu_out;
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("buffer kept after page write");

  property p_write_held;
    (state == WRITING) |-> stall_cpu_out;
  endproperty
  a_write_held: assert property (p_write_held) else $error("core ran during page write");

  property p_eeprom_discard;
    eeprom_write_active_in && (|loaded) |=> loaded == '0;
  endproperty
  a_eeprom_discard: assert property (p_eeprom_discard)
    else $error("loaded words survived EEPROM write");

  property p_eeprom_block;
    eeprom_write_active_in |-> !spm_ok ##1 !$rose(stall_cpu_out);
  endproperty
  a_eeprom_block: assert property (p_eeprom_block)
    else $error("programming during EEPROM write");

  property p_duration;
    $fell(stall_cpu_out) |-> stall_len == STALL_CYCLES;
  endproperty
  a_duration: assert property (p_duration) else $error("operation length wrong");

  property p_release;
    $fell(stall_cpu_out) |-> $past(op_done);
  endproperty
  a_release: assert property (p_release) else $error("stall released without completion");

  property p_byte_pick;
    ##2 1'b1 |-> lpm_byte_out == ($past(lpm_z_in[0], 2) ? $past(flash_rd_word_in[15:8]) :
                                 $past(flash_rd_word_in[7:0]));
  endproperty
  a_byte_pick: assert property (p_byte_pick) else $error("byte read picked wrong byte");

  c_erase: cover property (erase_go ##1 stall_cpu_out);
  c_write: cover property (write_go ##1 flash_cmd_out.write);
  c_load: cover property (load_en ##1 (|loaded));
  c_expire: cover property (window_expire);
endmodule

// ### verif/core_flash_model.sv
// Purpose: Core and flash array seen from the sequencer's far side
// Assumes: The core issues one store-program at a time and idles while halted
// Notes: Unwritten flash words read as erased; idle request lines carry inverted data
`timescale 1ns/1ps
module core_flash_model #(
  parameter int PAGE_WORDS = 4 // Words per page
) (
  input wire logic clk_sys_in, // System clock
  input wire logic stall_cpu_in, // Core halt
  input wire flash_spm_pkg::flash_cmd_t flash_cmd_in, // Erase and write pulses
  input wire logic [14:0] flash_rd_addr_in, // Read word address
  output flash_spm_pkg::spm_req_t spm_out, // Store-program instruction
  output logic [15:0] flash_rd_word_out // Read word
);
  logic [15:0] mem [int];
  logic [14:0] erased_addr;
  initial begin
    spm_out = '0;
    flash_rd_word_out = 16'h0000;
  end
  // Flash array takes erase and word write pulses
  always @(posedge clk_sys_in) begin
    if (flash_cmd_in.erase) begin
      erased_addr = flash_cmd_in.addr;
      for (int i = 0; i < PAGE_WORDS; i++) begin
        mem.delete(int'(flash_cmd_in.addr) + i);
      end
    end
    if (flash_cmd_in.write) begin
      mem[int'(flash_cmd_in.addr)] = flash_cmd_in.data;
    end
  end
  // Word is ready well before the edge after the address
  always @(negedge clk_sys_in) begin
    flash_rd_word_out <= mem.exists(int'(flash_rd_addr_in)) ? mem[int'(flash_rd_addr_in)] :
                         flash_spm_pkg::ERASED_WORD;
  end
  // One store-program, gap edges after the call, never while halted
  task automatic issue(input int gap, input logic [15:0] z, input logic [15:0] w);
    while (stall_cpu_in !== 1'b0) @(posedge clk_sys_in);
    repeat (gap) @(posedge clk_sys_in);
    spm_out <= '{strobe: 1'b1, z: z, word: w};
    @(posedge clk_sys_in);
    spm_out <= '{strobe: 1'b0, z: ~z, word: ~w};
  endtask
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench for the flash self-program sequencer
// Assumes: Four-word pages and 20-cycle operations
// Notes: Registers reached over Avalon-MM; core model issues store-programs
`timescale 1ns/1ps
module tb;
  localparam int OPC = 20;
  localparam logic [3:0] CA = flash_spm_pkg::ADDR_CMD;
  localparam logic [3:0] SA = flash_spm_pkg::ADDR_STATUS;
  logic clk_sys_in, rst_n_in, avs_read_in, avs_write_in, fuse, eeprom, stall;
  logic avs_waitrequest_out;
  logic [3:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  flash_spm_pkg::spm_req_t spm;
  flash_spm_pkg::flash_cmd_t fcmd;
  logic [15:0] lpm_z_in, rd_word;
  logic [14:0] rd_addr;
  logic [7:0] lpm_byte;
  int bad_count = 0;
  int comparisons = 0;
  int stall_cycles = 0;
  flash_spm_seq #(.PAGE_WORDS(4), .OP_CYCLES(OPC)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .spm_in(spm), .self_program_fuse_in(fuse), .eeprom_write_active_in(eeprom),
    .stall_cpu_out(stall), .flash_cmd_out(fcmd), .lpm_z_in(lpm_z_in),
    .flash_rd_word_in(rd_word), .flash_rd_addr_out(rd_addr), .lpm_byte_out(lpm_byte));
  core_flash_model #(.PAGE_WORDS(4)) core_u (
    .clk_sys_in(clk_sys_in), .stall_cpu_in(stall), .flash_cmd_in(fcmd),
    .flash_rd_addr_in(rd_addr), .spm_out(spm), .flash_rd_word_out(rd_word));
  // Clock and halted-cycle count
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  always @(negedge clk_sys_in) begin
    if (stall === 1'b1) stall_cycles++;
  end
  function automatic logic [15:0] zp(input int p, input int w);
    return {p[12:0], w[1:0], 1'b0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    // Waitrequest and read data are taken at the rising edge only
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    check(n < 50, 1, "bus answer");
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0);
    check(rd, e, what);
  endtask
  task automatic load(input int gap, input logic [15:0] z, input logic [15:0] w);
    bus(1'b1, CA, {24'h0, flash_spm_pkg::CMD_LOAD});
    core_u.issue(gap, z, w);
  endtask
  // Erase or write, with halt start and length checked
  task automatic op(input logic [7:0] cmd, input logic [15:0] z);
    bus(1'b1, CA, {24'h0, cmd});
    stall_cycles = 0;
    core_u.issue(0, z, 16'h5a5a);
    @(negedge clk_sys_in);
    check(stall, 1'b1, "halt starts");
    repeat (OPC + 8) @(posedge clk_sys_in);
    check(stall_cycles, OPC + 1, "halt length");
  endtask
  task automatic byte_chk(input logic [15:0] z, input logic [7:0] e);
    @(posedge clk_sys_in);
    lpm_z_in <= z;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check(lpm_byte, e, "byte read");
  endtask
  task automatic test_done();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    test_done();
  end
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    fuse = 1'b1;
    eeprom = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 4'h0;
    avs_writedata_in = 32'h0;
    lpm_z_in = 16'h0000;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd_chk(SA, 32'h2, "status after reset");
    rd_chk(CA, 32'h0, "command after reset");
    rd_chk(4'h8, 32'h0, "unmapped read");
    load(0, zp(2, 1), 16'h1234);
    rd_chk(SA, 32'h2, "load with fuse unprogrammed");
    fuse <= flash_spm_pkg::FUSE_PROGRAMMED;
    load(4, zp(2, 1), 16'h1111);
    rd_chk(SA, 32'h0, "late store-program ignored");
    bus(1'b1, CA, {24'h0, flash_spm_pkg::CMD_LOAD});
    rd_chk(CA, 32'h1, "load pending");
    core_u.issue(0, zp(2, 3), 16'hbeef);
    rd_chk(CA, 32'h0, "pending cleared by load");
    load(3, zp(2, 0) | 16'h1, 16'hcafe);
    rd_chk(SA, 32'h8, "words loaded");
    op(flash_spm_pkg::CMD_ERASE, zp(2, 2));
    check(core_u.erased_addr, 15'h0008, "erased page");
    rd_chk(CA, 32'h0, "erase command cleared");
    load(1, zp(2, 1), 16'h0042);
    op(flash_spm_pkg::CMD_WRITE, zp(2, 0));
    rd_chk(SA, 32'h0, "buffer cleared after write");
    byte_chk(zp(2, 3), 8'hef);
    byte_chk(zp(2, 3) | 16'h1, 8'hbe);
    byte_chk(zp(2, 0), 8'hfe);
    byte_chk(zp(2, 1), 8'h42);
    byte_chk(zp(2, 2) | 16'h1, 8'hff);
    load(0, zp(3, 0), 16'h0001);
    bus(1'b1, CA, 32'h1 << flash_spm_pkg::CLEAR_BIT);
    rd_chk(SA, 32'h0, "clear bit empties buffer");
    load(0, zp(3, 1), 16'h0002);
    eeprom <= 1'b1;
    rd_chk(SA, 32'h4, "eeprom write drops words");
    load(0, zp(3, 2), 16'h0003);
    rd_chk(CA, 32'h0, "command refused during eeprom write");
    rd_chk(SA, 32'h4, "no load during eeprom write");
    eeprom <= 1'b0;
    rd_chk(SA, 32'h0, "idle at end");
    test_done();
  end
endmodule
